// ---- verilog/asr_pkg.sv ----
// Constants and types shared by the asynchronous serial receiver files
package asr_pkg;
   localparam logic       OP_MODE_ASYNC       = 1'b0;
   localparam logic       CLK_SRC_BAUD_GEN    = 1'b0;
   localparam logic       BIT_ORDER_MSB_FIRST = 1'b1;
   localparam logic       PARITY_ODD          = 1'b1;
   localparam logic       STOP_TWO            = 1'b1;
   localparam logic       LINE_IDLE           = 1'b1;
   localparam logic [3:0] CHAR_LEN_BASE       = 4'h5;
   localparam logic [3:0] START_PATTERN       = 4'h8;
   localparam logic [1:0] PHASE_BIT_START     = 2'h0;
   localparam logic [1:0] PHASE_DECIDE        = 2'h3;
   localparam logic [3:0] PRESC_ONE           = 4'h1;
   localparam logic [7:0] BAUD_COUNT_MIN      = 8'h02;
   localparam logic [7:0] HOLDING_RESET       = 8'h00;

   typedef enum logic [2:0] {
      RX_IDLE,
      RX_DATA,
      RX_PARITY,
      RX_STOP1,
      RX_STOP2
   } asr_rx_state_t;

   typedef struct packed {
      asr_rx_state_t state;
      logic [3:0]    hist;
      logic [1:0]    phase;
      logic [1:0]    votes;
      logic [2:0]    bitIdx;
      logic [7:0]    shift;
      logic          parBit;
      logic [7:0]    holding;
      logic          full;
      logic          parErr;
      logic          frmErr;
      logic          ovrErr;
      logic          irq;
   } asr_rx_regs_t;

   typedef struct packed {
      logic [2:0] prescCnt;
      logic [7:0] baudCnt;
      logic       tick;
   } asr_baud_regs_t;
endpackage

// ---- verilog/asr_sync.sv ----
// Two flip-flop synchroniser for signals arriving from outside the clock domain
module asr_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } asr_sync_regs_t;

   asr_sync_regs_t r_q;
   asr_sync_regs_t r_d;

   always_comb begin
      r_d        = r_q;
      r_d.stage1 = asyncIn;
      r_d.stage2 = r_q.stage1;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_q <= {RESET_VAL, RESET_VAL};
      end else begin
         r_q <= r_d;
      end
   end

   assign syncOut = r_q.stage2;
endmodule

// ---- verilog/asr_baud_gen.sv ----
// Prescaler and reload counter producing the baud generator clock as a one-cycle tick
module asr_baud_gen (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       run,
   input  wire logic [1:0] prescaleSel,
   input  wire logic [7:0] baudCountSetting,
   output logic            baudTick
);
   asr_pkg::asr_baud_regs_t r_q;
   asr_pkg::asr_baud_regs_t r_d;
   logic [2:0]              prescLimit;
   logic                    prescDone;

   // Codes 00..11 divide by 1, 2, 4, 8
   assign prescLimit = 3'((asr_pkg::PRESC_ONE << prescaleSel) - asr_pkg::PRESC_ONE);
   assign prescDone  = (r_q.prescCnt == prescLimit);

   always_comb begin
      r_d      = r_q;
      r_d.tick = 1'b0;
      if (!run) begin
         r_d.prescCnt = 3'h0;
         r_d.baudCnt  = 8'h00;
      end else if (prescDone) begin
         r_d.prescCnt = 3'h0;
         if (r_q.baudCnt == baudCountSetting - 8'h01) begin
            r_d.baudCnt = 8'h00;
            r_d.tick    = 1'b1;
         end else begin
            r_d.baudCnt = r_q.baudCnt + 8'h01;
         end
      end else begin
         r_d.prescCnt = r_q.prescCnt + 3'h1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign baudTick = r_q.tick;

   // With a legal setting two ticks are never adjacent
   property p_tick_gap;
      @(posedge core_clk) disable iff (sys_rst)
      (baudTick && baudCountSetting >= asr_pkg::BAUD_COUNT_MIN && $stable(baudCountSetting)) |=> !baudTick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("baud ticks adjacent with legal setting");
endmodule

// ---- verilog/asr_uart_rx.sv ----
// Asynchronous serial receiver: start detection, majority sampling, framing and error flags

// Behaviour
// - Receiver works as asynchronous serial only while the mode select is zero.
// - One serial bit lasts four baud generator clock periods.
// - Prescaler codes divide by 1, 2, 4, 8; total divisor prescale times count times four.
// - Character length is five to eight data bits from the length field.
// - Frame carries one or two stop bits by the stop length select.
// - Parity enable adds a parity bit after data; polarity bit picks its sense.
// - Low start bit, high stop bits, idle line high, NRZ coding.
// - Data bits arrive MSB first or LSB first by the bit order select.
// - While enabled, keep watching for start bits and receive a frame for each.
// - Good frame loads the holding register, sets the full flag, and rearms.
// - Interrupt request rises with the full flag when interrupts are enabled.
// - Reading the holding register clears the full flag.
// - Dropping enable mid-frame aborts at once; partial data is never loaded.
// - A frame with any error loads nothing and leaves the full flag alone.
// - Parity error set when received parity disagrees with the chosen sense.
// - Framing error set when first stop bit samples low; second stop unchecked.
// - Overrun set when a frame completes while previous data is unread.
// - All three error flags update at the first stop bit sample point.
// - Start is high then three low samples; bits decided two of three.
// - Error flags also raise the interrupt request when interrupts are enabled.
module asr_uart_rx (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       serialInPin,
   input  wire logic       opModeSel,
   input  wire logic       clockSourceSel,
   input  wire logic [1:0] charLengthSel,
   input  wire logic       stopLengthSel,
   input  wire logic       parityEnable,
   input  wire logic       parityPolarity,
   input  wire logic       bitOrderSel,
   input  wire logic       receiveEnable,
   input  wire logic       receiveIrqEnable,
   input  wire logic       receiveErrorClear,
   input  wire logic       holdingRead,
   input  wire logic [1:0] prescaleSel,
   input  wire logic [7:0] baudCountSetting,
   output logic      [7:0] receiveHoldingReg,
   output logic            receiveFullFlag,
   output logic            parityErrorFlag,
   output logic            framingErrorFlag,
   output logic            overrunFlag,
   output logic            receiveIrq
);
   asr_pkg::asr_rx_regs_t r_q;
   asr_pkg::asr_rx_regs_t r_d;
   logic                  lineSync;
   logic                  baudTick;
   logic                  rxActive;
   logic [2:0]            charLast;
   logic [1:0]            phaseNext;
   logic [1:0]            voteSum;
   logic                  bitDone;
   logic                  bitVal;
   logic [2:0]            dataPos;
   logic                  stopDecide;
   logic                  newParErr;
   logic                  newFrmErr;
   logic                  newOvrErr;
   logic                  loadGood;
   logic                  startSeen;

   asr_sync #(
      .WIDTH     (1),
      .RESET_VAL (asr_pkg::LINE_IDLE)
   ) u_line_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .asyncIn  (serialInPin),
      .syncOut  (lineSync)
   );

   asr_baud_gen u_baud_gen (
      .core_clk         (core_clk),
      .sys_rst          (sys_rst),
      .run              (rxActive),
      .prescaleSel      (prescaleSel),
      .baudCountSetting (baudCountSetting),
      .baudTick         (baudTick)
   );

   // Only the internal baud generator can pace the receiver; an external clock selection idles it
   assign rxActive = receiveEnable && (opModeSel == asr_pkg::OP_MODE_ASYNC)
                     && (clockSourceSel == asr_pkg::CLK_SRC_BAUD_GEN);

   assign charLast  = 3'(asr_pkg::CHAR_LEN_BASE + {2'h0, charLengthSel} - 4'h1);
   assign phaseNext = r_q.phase + 2'h1;
   assign voteSum   = r_q.votes + {1'b0, lineSync};
   // Third sample of a bit decides it; four ticks make one bit
   assign bitDone   = rxActive && baudTick && (r_q.state != asr_pkg::RX_IDLE)
                      && (phaseNext == asr_pkg::PHASE_DECIDE);
   assign bitVal    = voteSum[1];
   assign dataPos   = (bitOrderSel == asr_pkg::BIT_ORDER_MSB_FIRST) ? 3'(charLast - r_q.bitIdx)
                                                                    : r_q.bitIdx;
   assign startSeen = ({r_q.hist[2:0], lineSync} == asr_pkg::START_PATTERN);

   assign stopDecide = bitDone && (r_q.state == asr_pkg::RX_STOP1);
   assign newFrmErr  = stopDecide && !bitVal;
   assign newParErr  = stopDecide && parityEnable
                       && ((^r_q.shift ^ r_q.parBit) != parityPolarity);
   // A read in the same cycle counts as having drained the previous character
   assign newOvrErr  = stopDecide && r_q.full && !holdingRead;
   assign loadGood   = stopDecide && !newFrmErr && !newParErr && !newOvrErr;

   always_comb begin
      r_d = r_q;
      if (!rxActive) begin
         r_d.state = asr_pkg::RX_IDLE;
         r_d.hist  = 4'h0;
         r_d.phase = asr_pkg::PHASE_BIT_START;
         r_d.votes = 2'h0;
      end else if (baudTick) begin
         r_d.hist = {r_q.hist[2:0], lineSync};
         if (r_q.state == asr_pkg::RX_IDLE) begin
            if (startSeen) begin
               // Third low sample: one more tick finishes the start bit
               r_d.state  = asr_pkg::RX_DATA;
               r_d.phase  = asr_pkg::PHASE_DECIDE;
               r_d.votes  = 2'h0;
               r_d.bitIdx = 3'h0;
               r_d.shift  = 8'h00;
            end
         end else begin
            r_d.phase = phaseNext;
            r_d.votes = (phaseNext == asr_pkg::PHASE_BIT_START) ? 2'h0 : voteSum;
            if (bitDone) begin
               case (r_q.state)
                  asr_pkg::RX_DATA: begin
                     r_d.shift[dataPos] = bitVal;
                     if (r_q.bitIdx == charLast) begin
                        r_d.state  = parityEnable ? asr_pkg::RX_PARITY : asr_pkg::RX_STOP1;
                        r_d.bitIdx = 3'h0;
                     end else begin
                        r_d.bitIdx = r_q.bitIdx + 3'h1;
                     end
                  end
                  asr_pkg::RX_PARITY: begin
                     r_d.parBit = bitVal;
                     r_d.state  = asr_pkg::RX_STOP1;
                  end
                  asr_pkg::RX_STOP1: begin
                     // Second stop bit is waited out but never checked
                     r_d.state = (stopLengthSel == asr_pkg::STOP_TWO) ? asr_pkg::RX_STOP2
                                                                      : asr_pkg::RX_IDLE;
                  end
                  default: begin
                     r_d.state = asr_pkg::RX_IDLE;
                  end
               endcase
            end
         end
      end
      if (loadGood) begin
         r_d.holding = r_q.shift;
      end
      // Hardware set wins over a clear in the same cycle
      r_d.full   = loadGood || (r_q.full && !holdingRead);
      r_d.parErr = newParErr || (r_q.parErr && !receiveErrorClear);
      r_d.frmErr = newFrmErr || (r_q.frmErr && !receiveErrorClear);
      r_d.ovrErr = newOvrErr || (r_q.ovrErr && !receiveErrorClear);
      r_d.irq    = receiveIrqEnable && (r_d.full || r_d.parErr || r_d.frmErr || r_d.ovrErr);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_q         <= '0;
         r_q.state   <= asr_pkg::RX_IDLE;
         r_q.holding <= asr_pkg::HOLDING_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign receiveHoldingReg = r_q.holding;
   assign receiveFullFlag   = r_q.full;
   assign parityErrorFlag   = r_q.parErr;
   assign framingErrorFlag  = r_q.frmErr;
   assign overrunFlag       = r_q.ovrErr;
   assign receiveIrq        = r_q.irq;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   property p_good_load;
      loadGood |=> (receiveFullFlag && receiveHoldingReg == $past(r_q.shift));
   endproperty
   a_good_load: assert property (p_good_load) else $error("good frame not loaded");

   property p_err_no_load;
      (stopDecide && (newFrmErr || newParErr || newOvrErr))
      |=> ($stable(receiveHoldingReg) && !$rose(receiveFullFlag));
   endproperty
   a_err_no_load: assert property (p_err_no_load) else $error("errored frame changed holding data");

   property p_read_clear;
      (holdingRead && !loadGood) |=> !receiveFullFlag;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear full flag");

   property p_frame_err;
      (stopDecide && !bitVal) |=> framingErrorFlag;
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("low stop bit not flagged");

   property p_parity_err;
      (stopDecide && parityEnable && ((^r_q.shift ^ r_q.parBit) != parityPolarity)) |=> parityErrorFlag;
   endproperty
   a_parity_err: assert property (p_parity_err) else $error("parity mismatch not flagged");

   property p_overrun;
      (stopDecide && receiveFullFlag && !holdingRead) |=> (overrunFlag && $stable(receiveHoldingReg));
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");

   property p_flag_moment;
      $rose(framingErrorFlag) || $rose(parityErrorFlag) || $rose(overrunFlag)
      |-> ($past(r_q.state) == asr_pkg::RX_STOP1 && $past(bitDone));
   endproperty
   a_flag_moment: assert property (p_flag_moment) else $error("error flag set away from first stop");

   property p_full_irq;
      (receiveIrqEnable && loadGood) |=> (receiveIrq && receiveFullFlag);
   endproperty
   a_full_irq: assert property (p_full_irq) else $error("no interrupt with full flag");

   property p_err_irq;
      (receiveIrqEnable && (newFrmErr || newParErr || newOvrErr)) |=> receiveIrq;
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("no interrupt on receive error");

   property p_abort;
      !rxActive |=> (r_q.state == asr_pkg::RX_IDLE && !$rose(receiveFullFlag));
   endproperty
   a_abort: assert property (p_abort) else $error("receiver not reset on disable");

   property p_sticky;
      (framingErrorFlag && !receiveErrorClear) |=> framingErrorFlag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("framing flag lost without clear");

   property p_stop_two;
      (stopDecide && stopLengthSel == asr_pkg::STOP_TWO && rxActive) |=> r_q.state == asr_pkg::RX_STOP2;
   endproperty
   a_stop_two: assert property (p_stop_two) else $error("second stop bit not waited");

   property p_start_detect;
      (rxActive && baudTick && r_q.state == asr_pkg::RX_IDLE && startSeen) |=> r_q.state == asr_pkg::RX_DATA;
   endproperty
   a_start_detect: assert property (p_start_detect) else $error("start pattern not taken");

   property p_idle_hold;
      (r_q.state == asr_pkg::RX_IDLE && !(rxActive && baudTick && startSeen)) |=> r_q.state == asr_pkg::RX_IDLE;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("frame began without start pattern");

   // Sample history gives an independent view of the three votes
   property p_majority;
      bitDone |-> bitVal == ((r_q.hist[1] && r_q.hist[0]) || (r_q.hist[1] && lineSync) || (r_q.hist[0] && lineSync));
   endproperty
   a_majority: assert property (p_majority) else $error("bit not decided two of three");

   property p_data_end;
      (bitDone && r_q.state == asr_pkg::RX_DATA && r_q.bitIdx == charLast && !parityEnable) |=> r_q.state == asr_pkg::RX_STOP1;
   endproperty
   a_data_end: assert property (p_data_end) else $error("data length not honoured");

   property p_parity_slot;
      (bitDone && r_q.state == asr_pkg::RX_DATA && r_q.bitIdx == charLast && parityEnable) |=> r_q.state == asr_pkg::RX_PARITY;
   endproperty
   a_parity_slot: assert property (p_parity_slot) else $error("parity bit not expected after data");

   property p_msb_first;
      (bitDone && r_q.state == asr_pkg::RX_DATA && r_q.bitIdx == 3'h0 && bitOrderSel == asr_pkg::BIT_ORDER_MSB_FIRST)
      |=> r_q.shift[charLast] == $past(bitVal);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first bit not placed at top");

   property p_stop_one;
      (stopDecide && stopLengthSel != asr_pkg::STOP_TWO) |=> r_q.state == asr_pkg::RX_IDLE;
   endproperty
   a_stop_one: assert property (p_stop_one) else $error("single stop frame not ended");

   property p_full_cause;
      $rose(receiveFullFlag) |-> $past(loadGood);
   endproperty
   a_full_cause: assert property (p_full_cause) else $error("full flag set without good frame");

   property p_irq_off;
      !receiveIrqEnable |=> !receiveIrq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

   property p_err_clear;
      (receiveErrorClear && !stopDecide) |=> (!parityErrorFlag && !framingErrorFlag && !overrunFlag);
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error flags not cleared");
endmodule

// ---- sim/asr_line_model.sv ----
// Remote asynchronous serial transmitter model that drives the receiver line
module asr_line_model (
   input  wire logic        core_clk,
   input  wire logic        go,
   input  wire logic [7:0]  txData,
   input  wire logic [1:0]  charLengthSel,
   input  wire logic        stopLengthSel,
   input  wire logic        parityEnable,
   input  wire logic        parityPolarity,
   input  wire logic        bitOrderSel,
   input  wire logic        badParity,
   input  wire logic [1:0]  lowStops,
   input  wire logic [15:0] bitCycles,
   output logic             txLine,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] frame;
   logic        par;
   int          nBits;
   int          nFrame;
   initial begin
      txLine = asr_pkg::LINE_IDLE;
      busy = 1'b0;
   end
   // Frame is built whole at launch, so later format changes cannot bend it
   always begin
      @(posedge core_clk);
      if (go) begin
         nBits = 5 + int'(charLengthSel);
         frame = '1;
         frame[0] = 1'b0;
         par = parityPolarity ^ badParity;
         for (int i = 0; i < nBits; i++) begin
            frame[1 + i] = bitOrderSel ? txData[nBits - 1 - i] : txData[i];
            par = par ^ txData[i];
         end
         nFrame = nBits + 1;
         if (parityEnable) begin
            frame[nFrame] = par;
            nFrame++;
         end
         frame[nFrame] = ~lowStops[0];
         frame[nFrame + 1] = ~lowStops[1];
         nFrame += stopLengthSel ? 2 : 1;
         busy <= 1'b1;
         for (int i = 0; i < nFrame; i++) begin
            txLine <= frame[i];
            repeat (bitCycles) @(posedge core_clk);
         end
         txLine <= asr_pkg::LINE_IDLE;
         busy <= 1'b0;
      end
   end
endmodule

// ---- sim/test_async_serial_receiver_mode0.sv ----
// Self-checking bench for the asynchronous serial receiver
module test_async_serial_receiver_mode0;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, sys_rst, serialLine, opModeSel, clockSourceSel, stopLengthSel;
   logic        parityEnable, parityPolarity, bitOrderSel, receiveEnable, receiveIrqEnable;
   logic        receiveErrorClear, holdingRead, go, busy, badParity;
   logic        receiveFullFlag, parityErrorFlag, framingErrorFlag, overrunFlag, receiveIrq;
   logic [1:0]  charLengthSel, prescaleSel, lowStops;
   logic [7:0]  baudCountSetting, receiveHoldingReg, txData;
   logic [15:0] bitCycles;
   wire  [7:0]  status;
   int          mismatches, n_checks;
   assign status = {3'h0, receiveFullFlag, parityErrorFlag, framingErrorFlag, overrunFlag, receiveIrq};

   asr_uart_rx u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .serialInPin(serialLine),
      .opModeSel(opModeSel), .clockSourceSel(clockSourceSel), .charLengthSel(charLengthSel),
      .stopLengthSel(stopLengthSel), .parityEnable(parityEnable), .parityPolarity(parityPolarity),
      .bitOrderSel(bitOrderSel), .receiveEnable(receiveEnable), .receiveIrqEnable(receiveIrqEnable),
      .receiveErrorClear(receiveErrorClear), .holdingRead(holdingRead), .prescaleSel(prescaleSel),
      .baudCountSetting(baudCountSetting), .receiveHoldingReg(receiveHoldingReg),
      .receiveFullFlag(receiveFullFlag), .parityErrorFlag(parityErrorFlag),
      .framingErrorFlag(framingErrorFlag), .overrunFlag(overrunFlag), .receiveIrq(receiveIrq));

   asr_line_model u_line (.core_clk(core_clk), .go(go), .txData(txData), .charLengthSel(charLengthSel),
      .stopLengthSel(stopLengthSel), .parityEnable(parityEnable), .parityPolarity(parityPolarity),
      .bitOrderSel(bitOrderSel), .badParity(badParity), .lowStops(lowStops), .bitCycles(bitCycles),
      .txLine(serialLine), .busy(busy));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] expVal, input string what);
      n_checks++;
      if (seen !== expVal) begin
         mismatches++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, expVal);
      end
   endtask

   task automatic launch(input logic [7:0] d, input logic bp, input logic [1:0] ls);
      @(posedge core_clk);
      txData <= d;
      badParity <= bp;
      lowStops <= ls;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
   endtask

   // Waits for the model to finish, then two bit times for the stop decision to land
   task automatic settle();
      int k;
      k = 0;
      @(posedge core_clk);
      while (busy === 1'b1 && k < 20000) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= 20000) begin
         mismatches++;
         $display("[FAIL] %0t line model stuck busy", $time);
      end
      repeat (2 * bitCycles) @(posedge core_clk);
   endtask

   task automatic send(input logic [7:0] d, input logic bp, input logic [1:0] ls);
      launch(d, bp, ls);
      settle();
   endtask

   task automatic strobe(input logic rd, input logic clr);
      @(posedge core_clk);
      holdingRead <= rd;
      receiveErrorClear <= clr;
      @(posedge core_clk);
      holdingRead <= 1'b0;
      receiveErrorClear <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic t_formats();
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         charLengthSel <= 2'(i % 4);
         bitOrderSel <= i[2];
         parityEnable <= i[0];
         parityPolarity <= i[1];
         stopLengthSel <= i[1] ^ i[2];
         d = 8'hA5 + 8'(i);
         send(d, 1'b0, 2'b00);
         check(receiveHoldingReg, 8'(d & (8'hFF >> (3 - i % 4))), "data");
         check(status, 8'h11, "full and irq");
         strobe(1'b1, 1'b0);
         check(status, 8'h00, "read clears");
      end
      $display("t_formats done");
   endtask

   task automatic t_errors();
      @(posedge core_clk);
      stopLengthSel <= 1'b1;
      send(8'h3C, 1'b1, 2'b00);
      check(status, 8'h09, "parity error");
      check(receiveHoldingReg, 8'hAC, "held");
      strobe(1'b0, 1'b1);
      check(status, 8'h00, "error clear");
      send(8'h3C, 1'b0, 2'b01);
      check(status, 8'h05, "framing error");
      strobe(1'b0, 1'b1);
      send(8'h3C, 1'b0, 2'b10);
      check(status, 8'h11, "second stop");
      check(receiveHoldingReg, 8'h3C, "data");
      receiveIrqEnable <= 1'b0;
      send(8'h5A, 1'b0, 2'b00);
      check(status, 8'h12, "overrun");
      check(receiveHoldingReg, 8'h3C, "old data");
      receiveIrqEnable <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(status, 8'h13, "error irq");
      strobe(1'b1, 1'b1);
      check(status, 8'h00, "all clear");
      $display("t_errors done");
   endtask

   task automatic t_rates();
      for (int i = 0; i < 5; i++) begin
         @(posedge core_clk);
         prescaleSel <= 2'(i % 4);
         baudCountSetting <= (i == 4) ? 8'hFF : 8'h02;
         bitCycles <= 16'((1 << (i % 4)) * ((i == 4) ? 255 : 2) * 4);
         send(8'h96 ^ 8'(i), 1'b0, 2'b00);
         check(receiveHoldingReg, 8'h96 ^ 8'(i), "rate data");
         check(status, 8'h11, "rate full");
         strobe(1'b1, 1'b0);
      end
      // Counter may sit above a smaller setting: let it wrap before the next frame
      baudCountSetting <= 8'h20;
      repeat (300) @(posedge core_clk);
      for (int j = 0; j < 2; j++) begin
         bitCycles <= (j == 0) ? 16'h007D : 16'h0083;
         send(8'hC3, 1'b0, 2'b00);
         check(receiveHoldingReg, 8'hC3, "skewed rate");
         strobe(1'b1, 1'b0);
      end
      prescaleSel <= 2'h0;
      baudCountSetting <= 8'h02;
      bitCycles <= 16'h0008;
      repeat (300) @(posedge core_clk);
      $display("t_rates done");
   endtask

   task automatic t_abort();
      launch(8'h81, 1'b0, 2'b00);
      repeat (5 * bitCycles) @(posedge core_clk);
      receiveEnable <= 1'b0;
      settle();
      receiveEnable <= 1'b1;
      repeat (4) @(posedge core_clk);
      check(status, 8'h00, "abort dropped");
      send(8'h66, 1'b0, 2'b00);
      check(receiveHoldingReg, 8'h66, "after abort");
      strobe(1'b1, 1'b0);
      $display("t_abort done");
   endtask

   task automatic t_modes();
      opModeSel <= 1'b1;
      send(8'h55, 1'b0, 2'b00);
      check(status, 8'h00, "sync mode idle");
      opModeSel <= 1'b0;
      clockSourceSel <= 1'b1;
      send(8'h55, 1'b0, 2'b00);
      check(status, 8'h00, "ext clock idle");
      clockSourceSel <= 1'b0;
      send(8'h55, 1'b0, 2'b00);
      check(status, 8'h11, "async mode");
      $display("t_modes done");
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end
      else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      mismatches = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      {opModeSel, clockSourceSel, stopLengthSel, parityEnable, parityPolarity} = 5'h00;
      {bitOrderSel, receiveErrorClear, holdingRead, go, badParity} = 5'h00;
      receiveEnable = 1'b1;
      receiveIrqEnable = 1'b1;
      {charLengthSel, prescaleSel, lowStops} = 6'h00;
      baudCountSetting = 8'h02;
      txData = 8'h00;
      bitCycles = 16'h0008;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_formats();
      t_errors();
      t_rates();
      t_abort();
      t_modes();
      close_out();
   end

   // About four times the expected run length
   initial begin
      #400us;
      mismatches++;
      close_out();
   end
endmodule
